// >>> arr_pkg.sv
// constants shared by the result readout interface
package arr_pkg;

  // ----------------------------------------------------------------
  // word and lane layout
  // ----------------------------------------------------------------
  localparam int          WORD_W       = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  BITS_PER_WORD = 5'h10;
  localparam int          SER_DATA_LANE = 15;
  localparam int          SER_CLK_LANE  = 14;
  localparam int          SER_SYNC_LANE = 13;
  localparam logic [15:0] OE_ALL       = 16'hFFFF;
  localparam logic [15:0] OE_NONE      = 16'h0000;
  localparam logic [15:0] OE_MASTER    = 16'hE000;
  localparam logic [15:0] OE_SLAVE     = 16'h8000;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // synchronised pin vector positions
  // ----------------------------------------------------------------
  localparam int PIN_W    = 15;
  localparam int P_CSN    = 0;
  localparam int P_RDN    = 1;
  localparam int P_CNVN   = 2;
  localparam int P_SERSEL = 3;
  localparam int P_CODSEL = 4;
  localparam int P_BYTSEL = 5;
  localparam int P_CLKSRC = 6;
  localparam int P_RDMODE = 7;
  localparam int P_DIV0   = 8;
  localparam int P_DIV1   = 9;
  localparam int P_SCLK   = 10;
  localparam int P_PD     = 11;
  localparam int P_CLKINV = 12;
  localparam int P_SYNINV = 13;
  localparam int P_SPARE  = 14;

  // ----------------------------------------------------------------
  // serial clock divider: half period is 2**select reference cycles in master read-after-conversion mode, one cycle otherwise
  // ----------------------------------------------------------------
  localparam int          DIV_CNT_W  = 4;
  localparam logic [3:0]  HALF_BASE  = 4'h1;

  // ----------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------
  localparam int         BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL  = 2'h2;

endpackage : arr_pkg

// >>> arr_readout.sv
// result readout interface of a 16-bit sampling converter
module arr_readout
  import arr_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // host pins
  input  wire logic                chipSelectN,
  input  wire logic                readStrobeN,
  input  wire logic                sclkIn,
  output logic [WORD_W-1:0]        dataOut,
  output logic [WORD_W-1:0]        dataOe,
  output logic                     busy,
  output logic                     readErrorPulse,
  // configuration pins
  input  wire logic                convertStartN,
  input  wire logic                powerDownInput,
  input  wire logic                outputCodingSelect,
  input  wire logic                serialParallelSelect,
  input  wire logic                byteOrderSelect,
  input  wire logic                clockSourceSelect,
  input  wire logic                readModeDaisyInput,
  input  wire logic [1:0]          serialClockDividerSelect,
  input  wire logic                sclkInvert,
  input  wire logic                syncInvert,
  // converter core
  output logic                     convStart,
  input  wire logic                resultValid,
  input  wire logic [WORD_W-1:0]   resultData,
  output logic                     resultReady
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS1_r;
  logic [PIN_W-1:0] pinS2_r;
  logic [PIN_W-1:0] pinS3_r;

  assign pinRaw = {1'b0, syncInvert, sclkInvert, powerDownInput, sclkIn,
                   serialClockDividerSelect, readModeDaisyInput,
                   clockSourceSelect, byteOrderSelect, outputCodingSelect,
                   serialParallelSelect, convertStartN, readStrobeN,
                   chipSelectN};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_r <= 15'h7FFF;
      pinS2_r <= 15'h7FFF;
      pinS3_r <= 15'h7FFF;
    end else begin
      pinS1_r <= pinRaw;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end

  wire csLow     = !pinS2_r[P_CSN];
  wire bothLow   = csLow && !pinS2_r[P_RDN];
  wire serMode   = pinS2_r[P_SERSEL];
  wire slaveMode = pinS2_r[P_CLKSRC];
  wire rdcMode   = pinS2_r[P_RDMODE];
  wire startEdge = pinS3_r[P_CNVN] && !pinS2_r[P_CNVN];
  wire sclkRise  = !pinS3_r[P_SCLK] && pinS2_r[P_SCLK];
  wire sclkFall  = pinS3_r[P_SCLK] && !pinS2_r[P_SCLK];
  wire masterRac = serMode && !slaveMode && !rdcMode;
  wire masterRdc = serMode && !slaveMode && rdcMode;
  wire slaveRac  = serMode && slaveMode && !rdcMode;
  wire slaveRdc  = serMode && slaveMode && rdcMode;

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  logic convActive_r;
  logic busy_r;
  logic convStart_r;
  logic readErr_r;
  logic msDone;
  logic [CNT_W-1:0] bitCnt_r;

  wire startEv = startEdge && !convActive_r && !pinS2_r[P_PD];
  wire convEnd;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      convActive_r <= 1'b0;
      convStart_r  <= 1'b0;
    end else begin
      convStart_r <= startEv;
      if (startEv)
        convActive_r <= 1'b1;
      else if (convEnd)
        convActive_r <= 1'b0;
    end
  end

  wire busyClr = masterRac ? (msDone && !convActive_r) : convEnd;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (startEv) begin
      busy_r <= 1'b1;
    end else if (busyClr) begin
      busy_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // two-entry result buffer
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] bufMem_r [BUF_DEPTH];
  logic              wrPtr_r;
  logic              rdPtr_r;
  logic [1:0]        bufCnt_r;
  logic              bufRdy_r;
  logic              shBusy;

  wire push    = resultValid && bufRdy_r;
  wire bufVld  = bufCnt_r != 2'h0;
  wire pop     = bufVld && !shBusy;
  wire [1:0] cntNxt = bufCnt_r + {1'b0, push} - {1'b0, pop};
  assign convEnd = push;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r  <= 1'b0;
      rdPtr_r  <= 1'b0;
      bufCnt_r <= 2'h0;
      bufRdy_r <= 1'b1;
    end else begin
      if (push)
        wrPtr_r <= !wrPtr_r;
      if (pop)
        rdPtr_r <= !rdPtr_r;
      bufCnt_r <= cntNxt;
      bufRdy_r <= cntNxt != BUF_FULL;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push)
      bufMem_r[wrPtr_r] <= resultData;
  end

  // ----------------------------------------------------------------
  // output result register
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] result_r;
  logic              newWord_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r  <= WORD_RESET;
      newWord_r <= 1'b0;
    end else begin
      newWord_r <= pop;
      if (pop)
        result_r <= bufMem_r[rdPtr_r];
    end
  end

  wire outputCodingSelect_s = pinS2_r[P_CODSEL];
  wire [WORD_W-1:0] coded = outputCodingSelect_s ?
                            {!result_r[WORD_W-1], result_r[WORD_W-2:0]} :
                            result_r;
  wire [WORD_W-1:0] parWord = pinS2_r[P_BYTSEL] ?
                              {coded[7:0], coded[15:8]} : coded;

  // ----------------------------------------------------------------
  // serial shifter, shared by master and slave
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] shReg_r;
  logic              daisyBit_r;
  logic              msAct_r;
  logic              sclkLvl_r;
  logic [DIV_CNT_W-1:0] divCnt_r;

  wire loadRac  = newWord_r && (masterRac || slaveRac);
  wire loadRdc  = startEv && (masterRdc || slaveRdc);
  wire loadSh   = loadRac || loadRdc;
  wire [1:0] serialClockDividerSel = {pinS2_r[P_DIV1], pinS2_r[P_DIV0]};
  wire [DIV_CNT_W-1:0] halfLen = masterRac ?
       DIV_CNT_W'(HALF_BASE << serialClockDividerSel) : HALF_BASE;
  wire halfEnd  = msAct_r && (divCnt_r == halfLen - HALF_BASE);
  wire msFall   = halfEnd && sclkLvl_r;
  wire slvShift = serMode && slaveMode && csLow && sclkFall
                  && bitCnt_r != 5'h0;
  wire slvLatch = slaveRac && csLow && sclkRise;
  wire doShift  = msFall || slvShift;
  assign msDone = msFall && bitCnt_r == 5'h1;
  assign shBusy = msAct_r || loadSh;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shReg_r    <= WORD_RESET;
      bitCnt_r   <= 5'h0;
      daisyBit_r <= 1'b0;
    end else begin
      if (slvLatch)
        daisyBit_r <= pinS2_r[P_RDMODE];
      if (loadSh) begin
        shReg_r  <= coded;
        bitCnt_r <= BITS_PER_WORD;
      end else if (doShift) begin
        shReg_r  <= {shReg_r[WORD_W-2:0], slaveRac && daisyBit_r};
        bitCnt_r <= bitCnt_r - 5'h1;
      end
    end
  end

  // master clock: starts low, rise then fall per bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msAct_r   <= 1'b0;
      sclkLvl_r <= 1'b0;
      divCnt_r  <= 4'h0;
    end else if (loadSh && !slaveMode) begin
      msAct_r   <= 1'b1;
      sclkLvl_r <= 1'b0;
      divCnt_r  <= 4'h0;
    end else if (msAct_r) begin
      divCnt_r <= halfEnd ? 4'h0 : divCnt_r + 4'h1;
      if (halfEnd)
        sclkLvl_r <= !sclkLvl_r;
      if (msDone)
        msAct_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read error on unread bits at conversion end, slave read-during-conversion mode only
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      readErr_r <= 1'b0;
    else
      readErr_r <= convEnd && slaveRdc && bitCnt_r != 5'h0;
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] dataOut_r;
  logic [WORD_W-1:0] dataOe_r;

  wire sclkDrv = sclkLvl_r ^ pinS2_r[P_CLKINV];
  wire syncDrv = msAct_r ^ pinS2_r[P_SYNINV];
  wire [WORD_W-1:0] serWord = {shReg_r[WORD_W-1], sclkDrv, syncDrv,
                               13'h0000};
  wire [WORD_W-1:0] serOe = slaveMode ? OE_SLAVE : OE_MASTER;
  wire [WORD_W-1:0] outNxt = serMode ? serWord : parWord;
  wire [WORD_W-1:0] oeNxt = !bothLow ? OE_NONE :
                            serMode ? serOe : OE_ALL;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut_r <= WORD_RESET;
      dataOe_r  <= OE_NONE;
    end else begin
      dataOut_r <= outNxt;
      dataOe_r  <= oeNxt;
    end
  end

  assign dataOut        = dataOut_r;
  assign dataOe         = dataOe_r;
  assign busy           = busy_r;
  assign readErrorPulse = readErr_r;
  assign convStart      = convStart_r;
  assign resultReady    = bufRdy_r;

endmodule : arr_readout

// >>> arr_readout_checker.sv
// concurrent assertions on the pins of the result readout interface
module arr_readout_checker
  import arr_pkg::*;
(
  // clock, reset, host and configuration pins
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              chipSelectN,
  input wire logic              readStrobeN,
  input wire logic              serialParallelSelect,
  input wire logic              clockSourceSelect,
  input wire logic              byteOrderSelect,
  input wire logic              outputCodingSelect,
  input wire logic [WORD_W-1:0] dataOut,
  input wire logic [WORD_W-1:0] dataOe,
  input wire logic              busy,
  input wire logic              readErrorPulse,
  // converter core side
  input wire logic              convStart,
  input wire logic              resultValid,
  input wire logic              resultReady
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_OE_OFF: assert property (
    (chipSelectN || readStrobeN) [*4] |-> dataOe == OE_NONE)
    else $error("bus driven while deselected");
  AST_PAR_OE: assert property (
    (!chipSelectN && !readStrobeN && !serialParallelSelect) [*4]
    |-> dataOe == OE_ALL) else $error("parallel lanes not driven");
  AST_MST_OE: assert property (
    (!chipSelectN && !readStrobeN && serialParallelSelect
     && !clockSourceSelect) [*4] |-> dataOe == OE_MASTER)
    else $error("master serial lanes wrong");
  AST_SLV_OE: assert property (
    (!chipSelectN && !readStrobeN && serialParallelSelect
     && clockSourceSelect) [*4] |-> dataOe == OE_SLAVE)
    else $error("slave serial lane wrong");
  AST_CONV_PULSE: assert property (
    convStart |=> !convStart) else $error("start pulse too long");
  AST_CONV_BUSY: assert property (
    convStart |-> busy) else $error("busy low at start");
  AST_NO_RESTART: assert property (
    busy && $past(busy) |-> !convStart) else $error("restart while busy");
  AST_RDERR: assert property (
    readErrorPulse |=> !readErrorPulse) else $error("error pulse too long");
  AST_BUSY_END: assert property (
    busy && resultValid && resultReady && !serialParallelSelect |=> !busy)
    else $error("busy stays after result");
  AST_HOLD: assert property (
    ((dataOe == OE_ALL) && !(resultValid && resultReady)
     && $stable(byteOrderSelect) && $stable(outputCodingSelect)) [*5]
    |-> $stable(dataOut)) else $error("result changed without conversion");
  cover property (convStart);
  cover property (readErrorPulse);
  cover property ($fell(busy) && dataOe == OE_MASTER);
endmodule : arr_readout_checker

bind arr_readout arr_readout_checker i_chk (.*);

// >>> arr_core_model.sv
// behavioural converter core: answers each start after a set delay
module arr_core_model
  import arr_pkg::*;
(
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               rst_n,
  // handshake with the readout block
  input wire logic               convStart,
  input wire logic               resultReady,
  output logic                   resultValid,
  output logic [WORD_W-1:0]      resultData,
  // bench control
  input wire logic [WORD_W-1:0]  coreWord,
  input wire logic [WORD_W-1:0]  coreDly
);
  int cnt;
  // idle data toggles so a stale word is never mistaken for a result
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = 0;
      resultValid <= 1'b0;
      resultData <= 16'h0000;
    end else if (resultValid) begin
      if (resultReady) resultValid <= 1'b0;
    end else begin
      resultData <= ~resultData;
      if (convStart) cnt = coreDly;
      else if (cnt > 0) begin
        cnt = cnt - 1;
        if (cnt == 0) begin
          resultValid <= 1'b1;
          resultData <= coreWord;
        end
      end
    end
  end
endmodule : arr_core_model

// >>> adc_result_readout_interface_test.sv
// self-checking bench for the result readout interface
module adc_result_readout_interface_test import arr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, chipSelectN = 1, readStrobeN = 1, sclkIn = 1;
  logic convertStartN = 1, powerDownInput = 0, outputCodingSelect = 0;
  logic serialParallelSelect = 0, byteOrderSelect = 0, clockSourceSelect = 0;
  logic readModeDaisyInput = 0, sclkInvert = 0, syncInvert = 0;
  logic [1:0] serialClockDividerSelect = 2'h0;
  logic [WORD_W-1:0] coreWord = 16'h0000, coreDly = 16'h0014, mGot, w, prv, got;
  logic busy, readErrorPulse, convStart, resultValid, resultReady, errSeen;
  logic [WORD_W-1:0] dataOut, dataOe, resultData;
  int err_total = 0, checked = 0, mBits, mGap;
  arr_readout i_dut (.*);
  arr_core_model i_core (.*);
  always #50 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] xw(logic [15:0] v, logic c, logic s);
    v[15] = v[15] ^ c;
    return s ? {v[7:0], v[15:8]} : v;
  endfunction : xw
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // start a conversion, follow it to the end, capture master frames
  task automatic run(input logic [15:0] word, input logic expBusy);
    int n, last;
    logic prev, c;
    n = 0;
    prev = 1'b1;
    mBits = 0;
    errSeen = 1'b0;
    coreWord = word;
    convertStartN = 1'b0;
    while (n < 3000 && (n < 8 || busy !== 1'b0)) begin
      cyc(1);
      n++;
      if (n == 6) begin
        chk({15'h0000, busy}, {15'h0000, expBusy});
        convertStartN = 1'b1;
      end
      c = dataOut[14] ^ sclkInvert;
      if (c && !prev && (dataOut[13] ^ syncInvert)) begin
        mGot = {mGot[14:0], dataOut[15]};
        mBits++;
        if (mBits == 2) mGap = n - last;
        last = n;
      end
      prev = c;
      errSeen = errSeen | readErrorPulse;
    end
    if (n >= 3000) begin
      err_total++;
      tally_and_finish;
    end
  endtask : run
  task automatic sread(output logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      cyc(6);
      v = {v[14:0], dataOut[15]};
      sclkIn = ~sclkIn;
      cyc(6);
      sclkIn = ~sclkIn;
    end
  endtask : sread
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h766fee48));
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    chk(dataOe, OE_NONE);
    chipSelectN = 1'b0;
    readStrobeN = 1'b0;
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      {outputCodingSelect, byteOrderSelect} = 2'(k);
      run(w, 1'b1);
      cyc(4);
      chk(dataOut, xw(w, outputCodingSelect, byteOrderSelect));
      cyc(5);
      chk(dataOut, xw(w, outputCodingSelect, byteOrderSelect));
    end
    readStrobeN = 1'b1;
    cyc(4);
    chk(dataOe, OE_NONE);
    readStrobeN = 1'b0;
    powerDownInput = 1'b1;
    cyc(4);
    run(16'h1234, 1'b0);
    powerDownInput = 1'b0;
    cyc(4);
    chk(dataOut, xw(w, 1'b1, 1'b1));
    serialParallelSelect = 1'b1;
    for (int k = 0; k < 5; k++) begin
      serialClockDividerSelect = 2'(k);
      {syncInvert, sclkInvert} = 2'(k);
      readModeDaisyInput = (k == 4);
      outputCodingSelect = k[0];
      // during-conversion frame must fit early inside a longer conversion
      coreDly = (k == 4) ? 16'h0064 : 16'h0014;
      prv = w;
      w = 16'($urandom);
      cyc(4);
      run(w, 1'b1);
      chk(mGot, xw(k == 4 ? prv : w, k[0], 1'b0));
      if (k < 4) chk(16'(mBits), 16'h0010);
      if (k < 4) chk(16'(mGap), 16'(2 << k));
    end
    clockSourceSelect = 1'b1;
    readModeDaisyInput = 1'b0;
    for (int k = 0; k < 2; k++) begin
      sclkIn = k[0];
      w = 16'($urandom);
      cyc(4);
      run(w, 1'b1);
      chipSelectN = 1'b1;
      repeat (4) begin
        sclkIn = ~sclkIn;
        cyc(4);
      end
      chipSelectN = 1'b0;
      cyc(4);
      sread(got);
      chk(got, xw(w, outputCodingSelect, 1'b0));
    end
    readModeDaisyInput = 1'b1;
    coreDly = 16'h012c;
    run(16'($urandom), 1'b1);
    w = 16'($urandom);
    run(w, 1'b1);
    chk({15'h0000, errSeen}, 16'h0001);
    fork
      run(16'($urandom), 1'b1);
      sread(got);
    join
    chk(got, xw(w, outputCodingSelect, 1'b0));
    chk({15'h0000, errSeen}, 16'h0000);
    tally_and_finish;
  end
endmodule : adc_result_readout_interface_test
